// >>> design/cbc_pkg.sv
// Package of constants and types for the second comparator control block.
package cbc_pkg;
	// ==========================================================
	// Register map.
	localparam logic [11:0] CBC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] CBC_AUX_ADDR = 12'h004;
	localparam logic [11:0] CBC_PORT_ADDR = 12'h008;
	// ==========================================================
	// Control register field positions.
	localparam int CBC_EN_BIT = 7;
	localparam int CBC_RES_BIT = 6;
	localparam int CBC_OE_BIT = 5;
	localparam int CBC_POL_BIT = 4;
	localparam int CBC_REF_BIT = 2;
	localparam int CBC_CH_HI = 1;
	localparam int CBC_CH_LO = 0;
	localparam logic [7:0] CBC_CTRL_WMASK = 8'hB7;
	localparam logic [7:0] CBC_CTRL_RST = 8'h00;
	// Auxiliary register field positions.
	localparam int CBC_MIR_BIT = 6;
	localparam int CBC_GSS_BIT = 1;
	localparam int CBC_SYNC_BIT = 0;
	localparam logic [7:0] CBC_AUX_WMASK = 8'h03;
	localparam logic [7:0] CBC_AUX_RST = 8'h02;
	// Port data register layout.
	localparam int CBC_PORT_W = 4;
	localparam logic [3:0] CBC_PORT_DIR_RST = 4'hF;
	localparam logic [3:0] CBC_PORT_ANA_RST = 4'hF;
	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic enable;
		logic pin_drive_en;
		logic invert;
		logic ref_select;
		logic [1:0] chan_sel;
	} cbc_ctrl_t;
	typedef struct packed {
		logic gate_source_select;
		logic sync_en;
	} cbc_aux_t;
endpackage : cbc_pkg

// >>> design/cbc_top.sv
// Second comparator control block with APB register access.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Pin drives result only if enabled, pin drive bit set, direction bit zero.
// - Invert set: result reads 0 when noninverting input exceeds inverting input.
// - Gate source select clear lets comparator output gate the counter.
// - Port reads return 0 for every pin configured as analog.
// - With sync set, counter gate takes result latched on falling edge of counter clock enable.
module cbc_top import cbc_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic cmp_raw_in,
	input wire logic cnt_clk_in,
	input wire logic [3:0] port_pins_in,
	output logic cmp_b_enable_out,
	output logic cmp_b_ref_select_out,
	output logic [3:0] inv_pin_sel_out,
	output logic cmp_pin_out,
	output logic cmp_pin_oe_out,
	output logic cnt_gate_out,
	output logic gate_source_select_out
);
	// ==========================================================
	// Input synchronisers.
	logic cmp_s1_r, cmp_s2_r, clk_s1_r, clk_s2_r, clk_s3_r;
	logic [3:0] pin_s1_r, pin_s2_r;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
		end else begin
			cmp_s1_r <= cmp_raw_in;
			cmp_s2_r <= cmp_s1_r;
			clk_s1_r <= cnt_clk_in;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			pin_s1_r <= port_pins_in;
			pin_s2_r <= pin_s1_r;
		end
	end
	// ==========================================================
	// Registers and result conditioning.
	cbc_ctrl_t ctrl_r, ctrl_nxt;
	cbc_aux_t aux_r, aux_nxt;
	logic [3:0] dir_r, dir_nxt, ana_r, ana_nxt;
	logic res_r, res_nxt, sync_r, sync_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic rdy_r, rdy_nxt, err_r, err_nxt;
	logic pin_r, pin_nxt, oe_r, oe_nxt, gate_r, gate_nxt;
	logic [3:0] sel_r, sel_nxt;
	logic wr, setup, hit, res_now, cnt_fall;
	logic [7:0] ctrl_rd, aux_rd, wb;
	// Disabled comparator reads 0 so that stale core output never leaks.
	assign res_now = ctrl_r.enable & (cmp_s2_r ^ ctrl_r.invert);
	assign cnt_fall = clk_s3_r & ~clk_s2_r;
	assign setup = psel_in & ~penable_in;
	assign wr = psel_in & penable_in & pwrite_in & rdy_r;
	assign wb = pwdata_in[7:0];
	assign hit = (paddr_in == CBC_CTRL_ADDR) | (paddr_in == CBC_AUX_ADDR) |
		(paddr_in == CBC_PORT_ADDR);
	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[CBC_EN_BIT] = ctrl_r.enable;
		ctrl_rd[CBC_RES_BIT] = res_r;
		ctrl_rd[CBC_OE_BIT] = ctrl_r.pin_drive_en;
		ctrl_rd[CBC_POL_BIT] = ctrl_r.invert;
		ctrl_rd[CBC_REF_BIT] = ctrl_r.ref_select;
		ctrl_rd[CBC_CH_HI:CBC_CH_LO] = ctrl_r.chan_sel;
		aux_rd = 8'h00;
		aux_rd[CBC_MIR_BIT] = res_r;
		aux_rd[CBC_GSS_BIT] = aux_r.gate_source_select;
		aux_rd[CBC_SYNC_BIT] = aux_r.sync_en;
	end
	always_comb begin
		ctrl_nxt = ctrl_r;
		aux_nxt = aux_r;
		dir_nxt = dir_r;
		ana_nxt = ana_r;
		rdy_nxt = setup;
		err_nxt = setup & ~hit;
		rd_nxt = rd_r;
		if (wr && paddr_in == CBC_CTRL_ADDR) begin
			ctrl_nxt.enable = wb[CBC_EN_BIT];
			ctrl_nxt.pin_drive_en = wb[CBC_OE_BIT];
			ctrl_nxt.invert = wb[CBC_POL_BIT];
			ctrl_nxt.ref_select = wb[CBC_REF_BIT];
			ctrl_nxt.chan_sel = wb[CBC_CH_HI:CBC_CH_LO];
		end
		if (wr && paddr_in == CBC_AUX_ADDR) begin
			aux_nxt.gate_source_select = wb[CBC_GSS_BIT];
			aux_nxt.sync_en = wb[CBC_SYNC_BIT];
		end
		if (wr && paddr_in == CBC_PORT_ADDR) begin
			dir_nxt = pwdata_in[CBC_PORT_W-1:0];
			ana_nxt = pwdata_in[2*CBC_PORT_W-1:CBC_PORT_W];
		end
		if (setup && !pwrite_in) begin
			rd_nxt = 32'h0000_0000;
			case (paddr_in)
				CBC_CTRL_ADDR: rd_nxt[7:0] = ctrl_rd;
				CBC_AUX_ADDR: rd_nxt[7:0] = aux_rd;
				CBC_PORT_ADDR: rd_nxt[11:0] = {pin_s2_r & ~ana_r, ana_r, dir_r};
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end
	always_comb begin
		res_nxt = res_now;
		sync_nxt = cnt_fall ? res_now : sync_r;
		// Gate pulls the latched copy only when sync is set, avoiding a race with counting.
		gate_nxt = aux_r.sync_en ? sync_r : res_now;
		pin_nxt = res_now;
		oe_nxt = ctrl_r.enable & ctrl_r.pin_drive_en & ~dir_r[0];
		sel_nxt = 4'h0;
		for (int i = 0; i < 4; i++) begin
			sel_nxt[i] = (ctrl_r.chan_sel == 2'(i));
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ctrl_r <= '0;
			aux_r <= cbc_aux_t'(CBC_AUX_RST[1:0]);
			dir_r <= CBC_PORT_DIR_RST;
			ana_r <= CBC_PORT_ANA_RST;
			res_r <= 1'b0;
			sync_r <= 1'b0;
			rd_r <= 32'h0000_0000;
			rdy_r <= 1'b0;
			err_r <= 1'b0;
			pin_r <= 1'b0;
			oe_r <= 1'b0;
			gate_r <= 1'b0;
			sel_r <= 4'h1;
		end else begin
			ctrl_r <= ctrl_nxt;
			aux_r <= aux_nxt;
			dir_r <= dir_nxt;
			ana_r <= ana_nxt;
			res_r <= res_nxt;
			sync_r <= sync_nxt;
			rd_r <= rd_nxt;
			rdy_r <= rdy_nxt;
			err_r <= err_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
			gate_r <= gate_nxt;
			sel_r <= sel_nxt;
		end
	end
	// ==========================================================
	// Outputs, all straight from flip-flops.
	logic en_o_r, ref_o_r, gss_o_r;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			en_o_r <= 1'b0;
			ref_o_r <= 1'b0;
			gss_o_r <= CBC_AUX_RST[CBC_GSS_BIT];
		end else begin
			en_o_r <= ctrl_r.enable;
			ref_o_r <= ctrl_r.ref_select;
			gss_o_r <= aux_r.gate_source_select;
		end
	end
	assign prdata_out = rd_r;
	assign pready_out = rdy_r;
	assign pslverr_out = err_r;
	assign cmp_b_enable_out = en_o_r;
	assign cmp_b_ref_select_out = ref_o_r;
	assign inv_pin_sel_out = sel_r;
	assign cmp_pin_out = pin_r;
	assign cmp_pin_oe_out = oe_r;
	assign cnt_gate_out = gate_r;
	assign gate_source_select_out = gss_o_r;
	// ==========================================================
	// Assertions.
	property p_pin_oe;
		@(posedge mclk_in) disable iff (!rst_n_in)
		cmp_pin_oe_out |-> $past(ctrl_r.enable) && $past(ctrl_r.pin_drive_en) && !$past(dir_r[0]);
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("Pin driven without all enables.");
	property p_invert;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ctrl_r.enable && ctrl_r.invert && cmp_s2_r) |=> !res_r;
	endproperty
	a_invert: assert property (p_invert) else $error("Inverted result wrong.");
	property p_internal;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!ctrl_r.pin_drive_en |=> !cmp_pin_oe_out;
	endproperty
	a_internal: assert property (p_internal) else $error("Pin driven while internal.");
	property p_chan;
		@(posedge mclk_in) disable iff (!rst_n_in)
		##1 inv_pin_sel_out == (4'h1 << $past(ctrl_r.chan_sel));
	endproperty
	a_chan: assert property (p_chan) else $error("Channel select wrong.");
	property p_gate;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!aux_r.sync_en |=> cnt_gate_out == $past(res_now);
	endproperty
	a_gate: assert property (p_gate) else $error("Gate does not follow result.");
	property p_analog;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(setup && !pwrite_in && paddr_in == CBC_PORT_ADDR) |=> (prdata_out[11:8] & ana_r) == 4'h0;
	endproperty
	a_analog: assert property (p_analog) else $error("Analog pin read nonzero.");
	property p_sync;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!cnt_fall |=> sync_r == $past(sync_r);
	endproperty
	a_sync: assert property (p_sync) else $error("Latched result moved off edge.");
	property p_ref;
		@(posedge mclk_in) disable iff (!rst_n_in)
		##1 cmp_b_ref_select_out == $past(ctrl_r.ref_select);
	endproperty
	a_ref: assert property (p_ref) else $error("Reference select wrong.");
	property p_bit3;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(rdy_r && !pwrite_in && paddr_in == CBC_CTRL_ADDR) |-> prdata_out[3] == 1'b0;
	endproperty
	a_bit3: assert property (p_bit3) else $error("Bit 3 reads nonzero.");
	c_pin: cover property (@(posedge mclk_in) disable iff (!rst_n_in) cmp_pin_oe_out);
	c_sync: cover property (@(posedge mclk_in) disable iff (!rst_n_in) cnt_fall && aux_r.sync_en);
	c_err: cover property (@(posedge mclk_in) disable iff (!rst_n_in) pslverr_out);
endmodule : cbc_top
`default_nettype wire

// >>> test/cbc_analog_model.sv
// Behavioural model of the analog comparator core that sits beside the block.
`timescale 1ns/10ps
`default_nettype none
module cbc_analog_model (
	input wire logic mclk_in,
	input wire logic enable_in,
	input wire logic ref_sel_in,
	input wire logic [3:0] sel_in,
	input wire logic [7:0] pos_v_in,
	input wire logic [7:0] vref_v_in,
	input wire logic [31:0] neg_v_in,
	output logic raw_out
);
	logic [7:0] plus_v;
	logic [7:0] minus_v;
	logic junk_r = 1'b0;
	always_ff @(posedge mclk_in) junk_r <= ~junk_r;
	always_comb begin
		plus_v = ref_sel_in ? vref_v_in : pos_v_in;
		minus_v = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (sel_in[i]) minus_v = neg_v_in[8*i +: 8];
		end
		// A core that is switched off gives no valid answer, so it toggles.
		raw_out = enable_in ? (plus_v > minus_v) : junk_r;
	end
endmodule : cbc_analog_model
`default_nettype wire

// >>> test/test_comparator_two_control.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/10ps
`default_nettype none
module test_comparator_two_control import cbc_pkg::*;;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, raw, cnt_lvl = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'd64042, neg_v = 32'h0, rv;
	logic [7:0] pos_v = 8'h00, vref_v = 8'h00, c;
	logic [3:0] pins = 4'h0, dir, ana, sel;
	logic pready, pslverr, en, refs, pin, oe, gate, e, r, gss;
	logic [1:0] aux;
	int n_mismatch = 0, samples_checked = 0, cycles = 0;
	always #25 mclk = ~mclk;
	cbc_top uut (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .cmp_raw_in(raw), .cnt_clk_in(cnt_lvl),
		.port_pins_in(pins), .cmp_b_enable_out(en), .cmp_b_ref_select_out(refs),
		.inv_pin_sel_out(sel), .cmp_pin_out(pin), .cmp_pin_oe_out(oe), .cnt_gate_out(gate),
		.gate_source_select_out(gss));
	cbc_analog_model model (.mclk_in(mclk), .enable_in(en), .ref_sel_in(refs), .sel_in(sel),
		.pos_v_in(pos_v), .vref_v_in(vref_v), .neg_v_in(neg_v), .raw_out(raw));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic exp_res(input logic [7:0] k);
		logic [7:0] p;
		p = k[2] ? vref_v : pos_v;
		return k[7] & ((p > neg_v[8*k[1:0] +: 8]) ^ k[4]);
	endfunction : exp_res
	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", nm, x, g);
			n_mismatch++;
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// ==========================================================
	// Timeout.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		apb(0, CBC_CTRL_ADDR, 0); chk("ctrl rst", 32'h0, q);
		apb(0, CBC_AUX_ADDR, 0); chk("aux rst", 32'h2, q);
		chk("gss rst", 32'(CBC_AUX_RST[CBC_GSS_BIT]), gss);
		apb(0, 12'h00C, 0); chk("unmapped err", 32'h1, e);
		chk("unmapped data", 32'h0, q);
		for (int i = 0; i < 40; i++) begin
			rv = xs();
			c = (i == 0) ? 8'hFF : rv[7:0];
			aux = rv[9:8];
			{dir, ana} = rv[17:10];
			pins <= rv[21:18];
			rv = xs();
			pos_v <= rv[7:0];
			vref_v <= rv[15:8];
			neg_v <= xs();
			apb(1, CBC_CTRL_ADDR, {24'h0, c});
			apb(1, CBC_AUX_ADDR, {30'h0, aux});
			apb(1, CBC_PORT_ADDR, {24'h0, ana, dir});
			repeat (8) @(posedge mclk);
			r = exp_res(c);
			apb(0, CBC_CTRL_ADDR, 0); chk("ctrl", {c[7], r, c[5:4], 1'b0, c[2:0]}, q);
			apb(0, CBC_AUX_ADDR, 0); chk("aux", {r, 4'h0, aux}, q);
			apb(0, CBC_PORT_ADDR, 0); chk("port", {pins & ~ana, ana, dir}, q);
			chk("slverr", 32'h0, e);
			chk("gss", aux[1], gss);
			chk("sel", 4'h1 << c[1:0], sel);
			chk("ref", c[2], refs);
			chk("en", c[7], en);
			chk("oe", c[7] & c[5] & ~dir[0], oe);
			if (c[7] & c[5] & ~dir[0]) chk("pin", r, pin);
			if (aux == 2'b00) chk("gate", r, gate);
		end
		pos_v <= 8'h10;
		neg_v <= 32'h20;
		apb(1, CBC_CTRL_ADDR, 32'h80);
		apb(1, CBC_AUX_ADDR, 32'h1);
		cnt_lvl <= 1;
		repeat (8) @(posedge mclk);
		cnt_lvl <= 0;
		repeat (8) @(posedge mclk);
		chk("gate low", 1'b0, gate);
		cnt_lvl <= 1;
		pos_v <= 8'h30;
		repeat (8) @(posedge mclk);
		chk("gate held", 1'b0, gate);
		cnt_lvl <= 0;
		repeat (8) @(posedge mclk);
		chk("gate latched", 1'b1, gate);
		conclude();
	end
endmodule : test_comparator_two_control
`default_nettype wire
